//--- core/fbs_regs.svh
// constants for the flow-through burst sram core
`ifndef FBS_REGS_SVH
`define FBS_REGS_SVH
`define FBS_ADDR_W 18
`define FBS_WORDS 262144
`define FBS_LANES 4
`define FBS_LANE_W 8
`define FBS_DATA_W 32
`define FBS_FIFO_DEPTH 8
`define FBS_BURST_LEN 4
`define FBS_SLEEP_ENTER_CYC 2
`define FBS_SLEEP_EXIT_CYC 2
`define FBS_RST_BASE 18'h0_0000
`define FBS_RST_CNT 2'h0
`endif

//--- core/fbs_pkg.sv
// types shared by the flow-through burst sram core
`include "fbs_regs.svh"
package fbs_pkg;
    typedef struct packed {
        logic [`FBS_LANES-1:0] parity_lane;
        logic [`FBS_DATA_W-1:0] data;
    } fbs_word_t;

    typedef struct packed {
        logic [`FBS_ADDR_W-1:0] addr;
        logic [`FBS_LANES-1:0] lanes;
        fbs_word_t word;
    } fbs_beat_t;

    typedef enum logic [2:0] {
        FBS_OP_IDLE = 3'b001,
        FBS_OP_READ = 3'b010,
        FBS_OP_WRITE = 3'b100
    } fbs_op_t;

    typedef enum logic [3:0] {
        FBS_SL_AWAKE = 4'b0001,
        FBS_SL_ENTER = 4'b0010,
        FBS_SL_ASLEEP = 4'b0100,
        FBS_SL_EXIT = 4'b1000
    } fbs_sleep_t;
endpackage : fbs_pkg

//--- core/fbs_burst.sv
// burst address sequencer for the two lowest address bits
`timescale 1ns/1ps
`default_nettype none
module fbs_burst
(
    input wire logic [1:0] start,
    input wire logic [1:0] count,
    input wire logic interleave,
    output logic [1:0] low_addr
);
    always_comb
    begin
        if (interleave)
        begin
            low_addr = start ^ count; // R08
        end
        else
        begin
            low_addr = start + count; // R09
        end
    end
endmodule : fbs_burst
`default_nettype wire

//--- core/fbs_fifo.sv
// write beat buffer with an ordered view of its contents
`timescale 1ns/1ps
`default_nettype none
module fbs_fifo
#(
    parameter int W = 8,
    parameter int DEPTH = 8
)
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [DEPTH*W-1:0] view,
    output logic [DEPTH-1:0] view_valid
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CW-1:0] cnt;
    } fbs_fifo_state_t;

    fbs_fifo_state_t s;
    fbs_fifo_state_t next_s;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != CW'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr] = in_data;
            next_s.wr = s.wr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd = s.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: next_s.cnt = s.cnt + 1'b1;
            2'b01: next_s.cnt = s.cnt - 1'b1;
            default: next_s.cnt = s.cnt;
        endcase
    end

    // oldest entry first
    always_comb
    begin
        for (int i = 0; i < DEPTH; i++)
        begin
            view[i*W +: W] = s.mem[PW'(s.rd + PW'(i))];
            view_valid[i] = (CW'(i) < s.cnt);
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule : fbs_fifo
`default_nettype wire

//--- core/fbs_ctrl.sv
// flow-through burst sram: access control, burst, sleep and array
`timescale 1ns/1ps
`default_nettype none
`include "fbs_regs.svh"
// Operation
// R01: clock qualifier high makes the edge ignored; all state holds. Code still steps sleep and drains the write buffer.
// R02: read loads when qualified, all selects active, write high, load low.
// R03: read word flows from array to the pins with no output register.
// R04: read data drives only while output enable is low.
// R05: a new operation may be taken on the edge after a read.
// R06: any select inactive on a load edge deselects; pins go quiet.
// R07: burst counter gives up to four beats from one loaded address.
// R08: strap low gives linear order, high gives interleaved order.
// R09: counter works on the two low bits and wraps in the group.
// R10: advance high continues the burst, ignoring selects and write.
// R11: direction is caught at burst start and kept for the burst.
// R12: write loads when qualified, all selects active, write low.
// R13: pins stay quiet during every write data phase.
// R14: write data is taken on the edge after the address edge.
// R15: only lanes with active selects are written.
// R16: controller keeps off the data bus while outputs drive.
// R17: controller gives correct lane selects on every write beat.
// R18: sleep keeps contents; entry and exit take two cycles.
// R19: accesses pending at sleep are dropped; array stays intact.
// R20: controller deselects before sleep and during recovery.
// R21: controller loads a new address after a deselect.
// R22: pins stay quiet during the first clock after deselect.
// R23: after reset the device is deselected with pins quiet.
// R24: an unconnected strap counts as high, so interleaved.
// R25: each parity lane follows its byte lane on write and read.
module fbs_ctrl
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clock_qualifier_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic write_en_n,
    input wire logic advance_load,
    input wire logic [`FBS_LANES-1:0] byte_lane_select_n,
    input wire logic [`FBS_ADDR_W-1:0] addr,
    input wire logic out_en_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    input wire fbs_pkg::fbs_word_t dq_in,
    output fbs_pkg::fbs_word_t dq_out,
    output logic dq_oe,
    output logic asleep,
    output logic write_buffer_ready
);
    import fbs_pkg::*;

    localparam int BW = $bits(fbs_beat_t);
    localparam int DEPTH = `FBS_FIFO_DEPTH;

    typedef struct packed {
        fbs_op_t op;
        logic [`FBS_ADDR_W-1:0] base;
        logic [1:0] cnt;
        logic emerge;
        fbs_sleep_t sleep;
        logic [1:0] sleep_cnt;
    } fbs_state_t;

    localparam fbs_state_t RST_STATE = '{
        op: FBS_OP_IDLE,
        base: `FBS_RST_BASE,
        cnt: `FBS_RST_CNT,
        emerge: 1'b0,
        sleep: FBS_SL_AWAKE,
        sleep_cnt: 2'h0
    };

    fbs_state_t s;
    fbs_state_t next_s;

    fbs_word_t mem [0:`FBS_WORDS-1];

    logic interleave;
    logic [1:0] low_addr;
    logic [`FBS_ADDR_W-1:0] cur_addr;
    logic all_sel;
    logic push;
    fbs_beat_t push_beat;
    logic drain_valid;
    logic drain_ready;
    fbs_beat_t drain_beat;
    logic [DEPTH*BW-1:0] view;
    logic [DEPTH-1:0] view_valid;
    fbs_word_t rd_word;

    // a floating strap does not compare equal to low
    always_comb
    begin
        if (burst_order_strap == 1'b0)
        begin
            interleave = 1'b0; // R08
        end
        else
        begin
            interleave = 1'b1; // R24
        end
    end

    fbs_burst u_burst
    (
        .start(s.base[1:0]),
        .count(s.cnt),
        .interleave(interleave),
        .low_addr(low_addr)
    );

    assign cur_addr = {s.base[`FBS_ADDR_W-1:2], low_addr}; // R09

    assign all_sel = !chip_sel_first_n && chip_sel_second &&
                     !chip_sel_third_n;

    // operation sequencing and sleep handling
    always_comb
    begin
        next_s = s;
        push = 1'b0;
        push_beat.addr = cur_addr;
        push_beat.lanes = ~byte_lane_select_n; // R17
        push_beat.word = dq_in;

        // sleep input is not qualified by the clock qualifier
        case (s.sleep)
            FBS_SL_AWAKE:
            begin
                if (sleep_request)
                begin
                    next_s.sleep = FBS_SL_ENTER;
                    next_s.sleep_cnt = 2'h1;
                end
            end
            FBS_SL_ENTER:
            begin
                if (!sleep_request)
                begin
                    next_s.sleep = FBS_SL_EXIT;
                    next_s.sleep_cnt = 2'h1;
                end
                else if (s.sleep_cnt ==
                         2'(`FBS_SLEEP_ENTER_CYC - 1))
                begin
                    next_s.sleep = FBS_SL_ASLEEP; // R18
                end
                else
                begin
                    next_s.sleep_cnt = s.sleep_cnt + 1'b1;
                end
            end
            FBS_SL_ASLEEP:
            begin
                if (!sleep_request)
                begin
                    next_s.sleep = FBS_SL_EXIT;
                    next_s.sleep_cnt = 2'h1;
                end
            end
            FBS_SL_EXIT:
            begin
                if (sleep_request)
                begin
                    next_s.sleep = FBS_SL_ENTER;
                    next_s.sleep_cnt = 2'h1;
                end
                else if (s.sleep_cnt ==
                         2'(`FBS_SLEEP_EXIT_CYC - 1))
                begin
                    next_s.sleep = FBS_SL_AWAKE; // R18
                end
                else
                begin
                    next_s.sleep_cnt = s.sleep_cnt + 1'b1;
                end
            end
            default:
            begin
                next_s.sleep = FBS_SL_AWAKE;
                next_s.sleep_cnt = 2'h0;
            end
        endcase

        if (sleep_request || s.sleep != FBS_SL_AWAKE)
        begin
            // pending access is abandoned, never completed
            next_s.op = FBS_OP_IDLE; // R19
            next_s.cnt = `FBS_RST_CNT;
            next_s.emerge = 1'b0;
        end
        else if (!clock_qualifier_n)
        begin
            // data phase of the write loaded on the previous edge
            if (s.op == FBS_OP_WRITE && |push_beat.lanes)
            begin
                push = 1'b1; // R14
            end
            if (advance_load)
            begin
                // selects and write strobe are ignored here
                if (s.op != FBS_OP_IDLE) // R11
                begin
                    next_s.cnt = s.cnt + 1'b1; // R10
                end
            end
            else if (all_sel)
            begin
                next_s.base = addr; // R05
                next_s.cnt = `FBS_RST_CNT; // R07
                if (write_en_n)
                begin
                    next_s.op = FBS_OP_READ; // R02
                end
                else
                begin
                    next_s.op = FBS_OP_WRITE; // R12
                end
            end
            else
            begin
                next_s.op = FBS_OP_IDLE; // R06
                next_s.cnt = `FBS_RST_CNT;
            end
            next_s.emerge = (s.op == FBS_OP_IDLE) &&
                            (next_s.op != FBS_OP_IDLE); // R22
        end
        // with the qualifier high next_s equals s unless sleep is requested or active: the edge is ignored
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s <= RST_STATE; // R23
        end
        else
        begin
            s <= next_s; // R01
        end
    end

    fbs_fifo
    #(
        .W(BW),
        .DEPTH(DEPTH)
    )
    u_fifo
    (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(push),
        .in_ready(write_buffer_ready),
        .in_data(push_beat),
        .out_valid(drain_valid),
        .out_ready(drain_ready),
        .out_data(drain_beat),
        .view(view),
        .view_valid(view_valid)
    );

    // array is powered down while asleep, so writes wait
    assign drain_ready = (s.sleep != FBS_SL_ASLEEP);

    // array update, lane by lane with its parity bit
    always_ff @(posedge mclk)
    begin
        if (drain_valid && drain_ready)
        begin
            for (int j = 0; j < `FBS_LANES; j++)
            begin
                if (drain_beat.lanes[j])
                begin
                    mem[drain_beat.addr].data[j*`FBS_LANE_W +:
                        `FBS_LANE_W] <= drain_beat.word.data[
                        j*`FBS_LANE_W +: `FBS_LANE_W]; // R15
                    mem[drain_beat.addr].parity_lane[j] <=
                        drain_beat.word.parity_lane[j]; // R25
                end
            end
        end
    end

    // read word with buffered writes laid over it, newest last
    always_comb
    begin
        fbs_beat_t b;
        b = '0;
        rd_word = mem[cur_addr]; // R03
        for (int i = 0; i < DEPTH; i++)
        begin
            b = fbs_beat_t'(view[i*BW +: BW]);
            if (view_valid[i] && b.addr == cur_addr)
            begin
                for (int j = 0; j < `FBS_LANES; j++)
                begin
                    if (b.lanes[j])
                    begin
                        rd_word.data[j*`FBS_LANE_W +: `FBS_LANE_W] =
                            b.word.data[j*`FBS_LANE_W +:
                            `FBS_LANE_W];
                        rd_word.parity_lane[j] =
                            b.word.parity_lane[j]; // R25
                    end
                end
            end
        end
    end

    // flow-through: pins follow the array with no output register
    assign dq_out = rd_word; // R03

    always_comb
    begin
        dq_oe = (s.op == FBS_OP_READ) && // R13
                !out_en_n && // R04
                !s.emerge && // R22
                (s.sleep == FBS_SL_AWAKE) &&
                !sleep_request; // R19
    end

    assign asleep = (s.sleep == FBS_SL_ASLEEP);
endmodule : fbs_ctrl
`default_nettype wire

//--- verif/fbs_host.sv
// controller side of the shared data bus
`timescale 1ns/1ps
`default_nettype none
module fbs_host
(
    input wire logic mclk,
    input wire logic dq_oe,
    input wire fbs_pkg::fbs_word_t host_data,
    output fbs_pkg::fbs_word_t dq_in
);
    import fbs_pkg::*;
    fbs_word_t last = '0;
    always_ff @(posedge mclk)
    begin
        last <= dq_in;
    end
    // released while the device drives: show a moving value
    assign dq_in = dq_oe ? ~last : host_data;
endmodule : fbs_host
`default_nettype wire

//--- verif/fbs_ctrl_sva.sv
// port assertions for the flow-through burst sram core
`timescale 1ns/1ps
`default_nettype none
module fbs_ctrl_sva
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic clock_qualifier_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic write_en_n,
    input wire logic advance_load,
    input wire logic out_en_n,
    input wire logic sleep_request,
    input wire logic dq_oe,
    input wire logic asleep,
    input wire logic write_buffer_ready
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    wire logic all_sel = !chip_sel_first_n && chip_sel_second
        && !chip_sel_third_n;
    wire logic go = !clock_qualifier_n && !sleep_request && !asleep;
    wire logic rd = go && !advance_load && all_sel && write_en_n;
    wire logic wr = go && !advance_load && all_sel && !write_en_n;
    wire logic ds = go && !advance_load && !all_sel;
    property p_stall;
        clock_qualifier_n && !sleep_request |=>
            !$stable(out_en_n) || $stable(dq_oe);
    endproperty
    a_stall: assert property (p_stall)
        else $error("outputs moved on ignored edge");
    property p_oe;
        out_en_n |-> !dq_oe;
    endproperty
    a_oe: assert property (p_oe)
        else $error("driving with enable off");
    property p_rd;
        rd ##1 (rd && !out_en_n) |=> dq_oe || out_en_n;
    endproperty
    a_rd: assert property (p_rd)
        else $error("back to back read not driven");
    property p_cont;
        rd ##1 (go && advance_load && !out_en_n) |=> dq_oe || out_en_n;
    endproperty
    a_cont: assert property (p_cont)
        else $error("burst read beat not driven");
    property p_desel;
        ds |=> !dq_oe;
    endproperty
    a_desel: assert property (p_desel)
        else $error("driving after deselect");
    property p_emerge;
        ds ##1 rd |=> !dq_oe;
    endproperty
    a_emerge: assert property (p_emerge)
        else $error("driving in first cycle after deselect");
    property p_wr;
        wr |=> !dq_oe;
    endproperty
    a_wr: assert property (p_wr)
        else $error("driving in write data phase");
    property p_wr_burst;
        wr ##1 (go && advance_load) |=> !dq_oe;
    endproperty
    a_wr_burst: assert property (p_wr_burst)
        else $error("driving in write burst beat");
    property p_sleep_q;
        asleep |-> !dq_oe;
    endproperty
    a_sleep_q: assert property (p_sleep_q)
        else $error("driving while asleep");
    property p_sleep_in;
        !asleep && $rose(sleep_request) ##0 sleep_request [*3] |=> asleep;
    endproperty
    a_sleep_in: assert property (p_sleep_in)
        else $error("sleep entry not two cycles");
    property p_sleep_out;
        $fell(sleep_request) ##0 !sleep_request [*3] |=> !asleep;
    endproperty
    a_sleep_out: assert property (p_sleep_out)
        else $error("sleep exit not two cycles");
    property p_reset;
        disable iff (1'b0)
        !rstn |=> !dq_oe && !asleep && write_buffer_ready;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset state wrong");
endmodule : fbs_ctrl_sva
`default_nettype wire

//--- verif/fbs_ctrl_tb.sv
// self-checking bench for the flow-through burst sram core
`timescale 1ns/1ps
`default_nettype none
`include "fbs_regs.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
    miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end
module fbs_ctrl_tb;
    import fbs_pkg::*;
    logic mclk = 0;
    logic rstn = 0;
    logic qual_n = 0;
    logic sel1_n = 1;
    logic sel2 = 0;
    logic sel3_n = 1;
    logic we_n = 1;
    logic adv = 0;
    logic [`FBS_LANES-1:0] lanes_n = '1;
    logic [`FBS_ADDR_W-1:0] addr = '0;
    logic [`FBS_ADDR_W-1:0] base = 18'h0_0012;
    logic oe_n = 0;
    logic sleep = 0;
    logic strap = 0;
    fbs_word_t host_data = '0;
    fbs_word_t dq_in;
    fbs_word_t dq_out;
    fbs_word_t e5;
    fbs_word_t exp_w;
    logic dq_oe;
    logic asleep;
    logic wbr;
    int miscompares = 0;
    int n_tests = 0;
    fbs_ctrl fbs_ctrl_i (.mclk(mclk), .rstn(rstn), .clock_qualifier_n(qual_n),
        .chip_sel_first_n(sel1_n), .chip_sel_second(sel2),
        .chip_sel_third_n(sel3_n), .write_en_n(we_n), .advance_load(adv),
        .byte_lane_select_n(lanes_n), .addr(addr), .out_en_n(oe_n),
        .sleep_request(sleep), .burst_order_strap(strap), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .asleep(asleep),
        .write_buffer_ready(wbr));
    fbs_host fbs_host_i (.mclk(mclk), .dq_oe(dq_oe), .host_data(host_data),
        .dq_in(dq_in));
    always #10 mclk = ~mclk;
    function automatic fbs_word_t pat(input int k);
        return {4'(k), 16'h5a5a, 16'(k)};
    endfunction : pat
    // burst low bits of beat k, and the beat that reached low bits a
    function automatic logic [1:0] lo(input logic st, input logic [1:0] b,
        input logic [1:0] k);
        return st ? b ^ k : b + k;
    endfunction : lo
    function automatic logic [1:0] kof(input logic st, input logic [1:0] b,
        input logic [1:0] a);
        return st ? a ^ b : a - b;
    endfunction : kof
    // s: 0 all selects active, 1..3 one select inactive
    task automatic step(input logic [1:0] s, input logic a, input logic w,
        input logic [`FBS_ADDR_W-1:0] ad, input logic [3:0] ln,
        input fbs_word_t d);
        sel1_n = (s == 1);
        sel2 = (s != 2);
        sel3_n = (s == 3);
        adv = a;
        we_n = w;
        addr = ad;
        lanes_n = ln;
        host_data = d;
        @(posedge mclk);
        #1;
    endtask : step
    task automatic conclude();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude
    initial
    begin
        #20000;
        miscompares++;
        conclude();
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        #1;
        `CHK("oe_rst", 1'b0, dq_oe)
        `CHK("sleep_rst", 1'b0, asleep)
        `CHK("wbr_rst", 1'b1, wbr)
        rstn = 1;
        step(1, 0, 1, 0, '1, '0);
        step(0, 0, 0, 5, '1, '0);
        `CHK("oe_wr", 1'b0, dq_oe)
        step(1, 0, 1, 0, '0, pat(5));
        step(0, 0, 1, 5, '1, '0);
        `CHK("oe_emerge", 1'b0, dq_oe)
        `CHK("rd5", pat(5), dq_out)
        step(0, 0, 0, 5, '1, '0);
        step(0, 0, 1, 5, 4'b1010, pat(9));
        e5 = (pat(9) & 36'h5_00ff_00ff) | (pat(5) & ~36'h5_00ff_00ff);
        `CHK("oe_wr_rd", 1'b1, dq_oe)
        `CHK("rd_lanes", e5, dq_out)
        oe_n = 1;
        #1;
        `CHK("oe_off", 1'b0, dq_oe)
        oe_n = 0;
        for (int s = 1; s < 4; s++)
        begin
            step(0, 0, 1, 5, '1, '0);
            step(2'(s), 0, 1, 5, '1, '0);
            `CHK("oe_desel", 1'b0, dq_oe)
        end
        step(0, 0, 1, 5, '1, '0);
        step(0, 0, 1, 5, '1, '0);
        qual_n = 1;
        step(1, 0, 0, 0, '1, '0);
        `CHK("oe_stall", 1'b1, dq_oe)
        `CHK("rd_stall", e5, dq_out)
        qual_n = 0;
        for (int st = 0; st < 2; st++)
        begin
            strap = st[0];
            step(0, 0, 0, base, '1, '0);
            for (int k = 0; k < 4; k++)
                step(1, k < 3, 1, 0, '0, pat(k + 4 * st));
            strap = st[0] ? 1'b0 : 1'bz;
            step(0, 0, 1, base, '1, '0);
            for (int j = 0; j < 4; j++)
            begin
                exp_w = pat(kof(st[0], base[1:0],
                    lo(!st[0], base[1:0], 2'(j))) + 4 * st);
                `CHK("burst_rd", exp_w, dq_out)
                step(1, 1, 0, 0, '1, '0);
            end
        end
        step(1, 0, 1, 0, '1, '0);
        sleep = 1;
        repeat (3) step(1, 0, 1, 0, '1, '0);
        `CHK("asleep", 1'b1, asleep)
        sleep = 0;
        repeat (3) step(1, 0, 1, 0, '1, '0);
        `CHK("awake", 1'b0, asleep)
        step(0, 0, 1, 5, '1, '0);
        `CHK("rd_sleep", e5, dq_out)
        `CHK("wbr", 1'b1, wbr)
        conclude();
    end
endmodule : fbs_ctrl_tb
bind fbs_ctrl fbs_ctrl_sva fbs_ctrl_sva_i (.mclk(mclk), .rstn(rstn),
    .clock_qualifier_n(clock_qualifier_n), .write_en_n(write_en_n),
    .chip_sel_first_n(chip_sel_first_n), .chip_sel_second(chip_sel_second),
    .chip_sel_third_n(chip_sel_third_n), .advance_load(advance_load),
    .out_en_n(out_en_n), .sleep_request(sleep_request), .dq_oe(dq_oe),
    .asleep(asleep), .write_buffer_ready(write_buffer_ready));
`default_nettype wire
